//--- hw/synth_cfg_pkg.sv
// Register indices, field positions, reset values and fixed bit patterns
// of the synthesizer reference path and VCO calibration register bank.
// Assumes a 32-bit APB bus where each 16-bit register takes one word.
package synth_cfg_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CAL_LAUNCH = 8'h00;
    localparam logic [7:0] IDX_CAL_CLK_DIV = 8'h01;
    localparam logic [7:0] IDX_LAUNCH_COUNT = 8'h02;
    localparam logic [7:0] IDX_AMPLITUDE_CAL_DELAY = 8'h04;
    localparam logic [7:0] IDX_CAL_FORCE = 8'h08;
    localparam logic [7:0] IDX_REF_DOUBLER = 8'h09;
    localparam logic [7:0] IDX_REF_SCALER = 8'h0A;
    localparam logic [7:0] IDX_REF_POST_DIV = 8'h0B;
    localparam logic [7:0] IDX_REF_PRE_DIV = 8'h0C;
    localparam logic [7:0] IDX_PUMP_GAIN = 8'h0E;
    localparam logic [7:0] IDX_FORCED_AMPLITUDE = 8'h10;
    localparam logic [7:0] IDX_AMPLITUDE_START = 8'h11;
    localparam logic [7:0] IDX_FORCED_BAND = 8'h13;
    localparam logic [7:0] IDX_CORE_SELECT = 8'h14;

    // Field positions (low bit) inside the 16-bit registers.
    localparam int POS_LAUNCH = 3;
    localparam int POS_CAL_CLK_DIV = 0;
    localparam int POS_AMP_DELAY = 8;
    localparam int POS_AMP_FORCE = 14;
    localparam int POS_BAND_FORCE = 11;
    localparam int POS_DOUBLER = 12;
    localparam int POS_SCALE = 7;
    localparam int POS_POST_DIV = 4;
    localparam int POS_PRE_DIV = 0;
    localparam int POS_PUMP_GAIN = 4;
    localparam int POS_FORCED_AMP = 0;
    localparam int POS_AMP_START = 0;
    localparam int POS_FORCED_BAND = 0;
    localparam int POS_CORE_SEL = 11;
    localparam int POS_CORE_FORCE = 10;

    // Reset values.
    localparam logic RST_LAUNCH = 1'b0;
    localparam logic [2:0] RST_CAL_CLK_DIV = 3'h3;
    localparam logic [7:0] RST_AMP_DELAY = 8'h0A;
    localparam logic RST_AMP_FORCE = 1'b0;
    localparam logic RST_BAND_FORCE = 1'b0;
    localparam logic RST_DOUBLER = 1'b0;
    localparam logic [4:0] RST_SCALE = 5'h01;
    localparam logic [7:0] RST_POST_DIV = 8'h01;
    localparam logic [11:0] RST_PRE_DIV = 12'h001;
    localparam logic [2:0] RST_PUMP_GAIN = 3'h7;
    localparam logic [8:0] RST_FORCED_AMP = 9'h080;
    localparam logic [8:0] RST_AMP_START = 9'h0FA;
    localparam logic [7:0] RST_FORCED_BAND = 8'hB7;
    localparam logic [2:0] RST_CORE_SEL = 3'h7;
    localparam logic RST_CORE_FORCE = 1'b0;

    // Fixed bit patterns that read back around the fields.
    localparam logic [15:0] FIX_CAL_LAUNCH = 16'h2410;
    localparam logic [15:0] FIX_CAL_CLK_DIV = 16'h0808;
    localparam logic [15:0] FIX_AMP_DELAY = 16'h0043;
    localparam logic [15:0] FIX_CAL_FORCE = 16'h2000;
    localparam logic [15:0] FIX_DOUBLER = 16'h0604;
    localparam logic [15:0] FIX_SCALER = 16'h1058;
    localparam logic [15:0] FIX_POST_DIV = 16'h0008;
    localparam logic [15:0] FIX_PRE_DIV = 16'h5000;
    localparam logic [15:0] FIX_PUMP_GAIN = 16'h1E00;
    localparam logic [15:0] FIX_FORCED_BAND = 16'h2700;
    localparam logic [15:0] FIX_CORE_SELECT = 16'hC048;

    // Smallest comparator delay that calibrates correctly everywhere.
    localparam logic [7:0] MIN_AMP_DELAY = 8'h0A;

endpackage

//--- hw/synth_cfg_regs.sv
// APB register bank for the synthesizer reference path, charge pump and
// VCO calibration controls, with the calibration clock tick and launch.
// Assumes one clock domain and a well-behaved APB master.
//
// Local design decision: register access over APB.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////

// How it works
// - Doubler enable in bit 12 of index 9, reset 0, 1 doubles reference.
// - Multiplier factor bits 11..7 of index 10, reset 1; only 1, 3, 7 legal.
// - Eight-bit post-divider in bits 11..4 of index 11, reset 1.
// - Twelve-bit pre-divider in bits 11..0 of index 12, reset 1.
// - Charge-pump gain bits 6..4 of index 14, reset 7; codes 2, 6 reserved.
// - Amplitude force bit makes calibration use the forced amplitude value.
// - Amplitude search starts from index 17 value, reset 250.
// - Band force bit makes the band come from index 19, reset 183.
// - Core select bits 13..11 of index 20 give start or forced core.
// - Core force bit 10 of index 20 locks the oscillator to that core.
// - Calibration clock is reference divided by 1, 2, 4 or 8.
// - Writing one to launch bit 3 of index 0 starts a calibration.
module synth_cfg_regs
#(
    parameter int ADDR_W = 12
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Reference path
    output logic ref_doubler_en,
    output logic [4:0] ref_scale_factor,
    output logic [7:0] ref_post_div,
    output logic [11:0] ref_pre_div,
    output logic [2:0] pump_gain,
    // Calibration controls
    output logic [7:0] amplitude_cal_delay,
    output logic amplitude_force,
    output logic band_force,
    output logic [8:0] forced_amplitude,
    output logic [8:0] amplitude_start,
    output logic [8:0] amplitude_seed,
    output logic [7:0] forced_band,
    output logic [2:0] core_select,
    output logic core_force,
    output logic [2:0] cal_clk_div,
    output logic cal_clk_tick,
    output logic freq_calib_launch
);

    ////////////////////////////////////////////////////////////////////////////

    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic doubler_reg;
    logic [4:0] scale_reg;
    logic [7:0] post_div_reg;
    logic [11:0] pre_div_reg;
    logic [2:0] pump_gain_reg;
    logic [7:0] amp_delay_reg;
    logic amp_force_reg;
    logic band_force_reg;
    logic [8:0] forced_amp_reg;
    logic [8:0] amp_start_reg;
    logic [8:0] amp_seed_reg;
    logic [7:0] forced_band_reg;
    logic [2:0] core_sel_reg;
    logic core_force_reg;
    logic [2:0] cal_div_reg;
    logic launch_bit_reg;
    logic launch_reg;
    logic [7:0] launch_count_reg;
    logic [2:0] tick_cnt_reg;
    logic tick_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode. Only the low half-word carries data, so a write needs
    // both low byte lanes; a partial write would leave a field half-updated.

    wire logic [ADDR_W-3:0] word_idx = paddr[ADDR_W-1:2];
    wire logic aligned = (paddr[1:0] == 2'h0);
    wire logic setup_phase = psel && !penable;
    wire logic access_done = psel && penable && pready_reg;
    wire logic lanes_ok = (pstrb[1:0] == 2'h3);

    function automatic logic hit(input logic [ADDR_W-3:0] idx, input logic [7:0] reg_idx);
        hit = (idx == (ADDR_W-2)'(reg_idx));
    endfunction

    wire logic hit_launch = hit(word_idx, synth_cfg_pkg::IDX_CAL_LAUNCH);
    wire logic hit_clk_div = hit(word_idx, synth_cfg_pkg::IDX_CAL_CLK_DIV);
    wire logic hit_count = hit(word_idx, synth_cfg_pkg::IDX_LAUNCH_COUNT);
    wire logic hit_delay = hit(word_idx, synth_cfg_pkg::IDX_AMPLITUDE_CAL_DELAY);
    wire logic hit_force = hit(word_idx, synth_cfg_pkg::IDX_CAL_FORCE);
    wire logic hit_doubler = hit(word_idx, synth_cfg_pkg::IDX_REF_DOUBLER);
    wire logic hit_scaler = hit(word_idx, synth_cfg_pkg::IDX_REF_SCALER);
    wire logic hit_post = hit(word_idx, synth_cfg_pkg::IDX_REF_POST_DIV);
    wire logic hit_pre = hit(word_idx, synth_cfg_pkg::IDX_REF_PRE_DIV);
    wire logic hit_pump = hit(word_idx, synth_cfg_pkg::IDX_PUMP_GAIN);
    wire logic hit_famp = hit(word_idx, synth_cfg_pkg::IDX_FORCED_AMPLITUDE);
    wire logic hit_start = hit(word_idx, synth_cfg_pkg::IDX_AMPLITUDE_START);
    wire logic hit_band = hit(word_idx, synth_cfg_pkg::IDX_FORCED_BAND);
    wire logic hit_core = hit(word_idx, synth_cfg_pkg::IDX_CORE_SELECT);

    wire logic mapped = aligned && (hit_launch || hit_clk_div || hit_count || hit_delay || hit_force
        || hit_doubler || hit_scaler || hit_post || hit_pre || hit_pump || hit_famp || hit_start
        || hit_band || hit_core);
    wire logic bad_access = !mapped || (pwrite && !lanes_ok);
    wire logic wr_ok = access_done && pwrite && !pslverr_reg;
    wire logic [15:0] wd = pwdata[15:0];

    ////////////////////////////////////////////////////////////////////////////
    // Read assembly: fields sit over the fixed pattern of each register except indices 2, 16 and 17, which read zero-extended.

    wire logic [15:0] rd_launch = synth_cfg_pkg::FIX_CAL_LAUNCH
        | (16'(launch_bit_reg) << synth_cfg_pkg::POS_LAUNCH);
    wire logic [15:0] rd_clk_div = synth_cfg_pkg::FIX_CAL_CLK_DIV
        | (16'(cal_div_reg) << synth_cfg_pkg::POS_CAL_CLK_DIV);
    wire logic [15:0] rd_delay = synth_cfg_pkg::FIX_AMP_DELAY
        | (16'(amp_delay_reg) << synth_cfg_pkg::POS_AMP_DELAY);
    wire logic [15:0] rd_force = synth_cfg_pkg::FIX_CAL_FORCE
        | (16'(amp_force_reg) << synth_cfg_pkg::POS_AMP_FORCE)
        | (16'(band_force_reg) << synth_cfg_pkg::POS_BAND_FORCE);
    wire logic [15:0] rd_doubler = synth_cfg_pkg::FIX_DOUBLER
        | (16'(doubler_reg) << synth_cfg_pkg::POS_DOUBLER);
    wire logic [15:0] rd_scaler = synth_cfg_pkg::FIX_SCALER
        | (16'(scale_reg) << synth_cfg_pkg::POS_SCALE);
    wire logic [15:0] rd_post = synth_cfg_pkg::FIX_POST_DIV
        | (16'(post_div_reg) << synth_cfg_pkg::POS_POST_DIV);
    wire logic [15:0] rd_pre = synth_cfg_pkg::FIX_PRE_DIV
        | (16'(pre_div_reg) << synth_cfg_pkg::POS_PRE_DIV);
    wire logic [15:0] rd_pump = synth_cfg_pkg::FIX_PUMP_GAIN
        | (16'(pump_gain_reg) << synth_cfg_pkg::POS_PUMP_GAIN);
    wire logic [15:0] rd_band = synth_cfg_pkg::FIX_FORCED_BAND
        | (16'(forced_band_reg) << synth_cfg_pkg::POS_FORCED_BAND);
    wire logic [15:0] rd_core = synth_cfg_pkg::FIX_CORE_SELECT
        | (16'(core_sel_reg) << synth_cfg_pkg::POS_CORE_SEL)
        | (16'(core_force_reg) << synth_cfg_pkg::POS_CORE_FORCE);

    wire logic [15:0] rd_mux =
        hit_launch ? rd_launch :
        hit_clk_div ? rd_clk_div :
        hit_count ? {8'h00, launch_count_reg} :
        hit_delay ? rd_delay :
        hit_force ? rd_force :
        hit_doubler ? rd_doubler :
        hit_scaler ? rd_scaler :
        hit_post ? rd_post :
        hit_pre ? rd_pre :
        hit_pump ? rd_pump :
        hit_famp ? {7'h00, forced_amp_reg} :
        hit_start ? {7'h00, amp_start_reg} :
        hit_band ? rd_band :
        hit_core ? rd_core : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // No wait states: the answer is prepared in the setup cycle.

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= setup_phase;
            pslverr_reg <= setup_phase && bad_access;
            if (setup_phase)
            begin
                prdata_reg <= (pwrite || !mapped) ? 32'h0000_0000 : {16'h0000, rd_mux};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field storage. Fixed bits in the write data are ignored.

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            doubler_reg <= synth_cfg_pkg::RST_DOUBLER;
            scale_reg <= synth_cfg_pkg::RST_SCALE;
            post_div_reg <= synth_cfg_pkg::RST_POST_DIV;
            pre_div_reg <= synth_cfg_pkg::RST_PRE_DIV;
            pump_gain_reg <= synth_cfg_pkg::RST_PUMP_GAIN;
            amp_delay_reg <= synth_cfg_pkg::RST_AMP_DELAY;
            amp_force_reg <= synth_cfg_pkg::RST_AMP_FORCE;
            band_force_reg <= synth_cfg_pkg::RST_BAND_FORCE;
            forced_amp_reg <= synth_cfg_pkg::RST_FORCED_AMP;
            amp_start_reg <= synth_cfg_pkg::RST_AMP_START;
            forced_band_reg <= synth_cfg_pkg::RST_FORCED_BAND;
            core_sel_reg <= synth_cfg_pkg::RST_CORE_SEL;
            core_force_reg <= synth_cfg_pkg::RST_CORE_FORCE;
            cal_div_reg <= synth_cfg_pkg::RST_CAL_CLK_DIV;
            launch_bit_reg <= synth_cfg_pkg::RST_LAUNCH;
        end
        else if (wr_ok)
        begin
            if (hit_doubler)
                doubler_reg <= wd[synth_cfg_pkg::POS_DOUBLER];
            if (hit_scaler)
                scale_reg <= wd[synth_cfg_pkg::POS_SCALE +: 5];
            if (hit_post)
                post_div_reg <= wd[synth_cfg_pkg::POS_POST_DIV +: 8];
            if (hit_pre)
                pre_div_reg <= wd[synth_cfg_pkg::POS_PRE_DIV +: 12];
            if (hit_pump)
                pump_gain_reg <= wd[synth_cfg_pkg::POS_PUMP_GAIN +: 3];
            if (hit_delay)
                amp_delay_reg <= wd[synth_cfg_pkg::POS_AMP_DELAY +: 8];
            if (hit_force)
            begin
                amp_force_reg <= wd[synth_cfg_pkg::POS_AMP_FORCE];
                band_force_reg <= wd[synth_cfg_pkg::POS_BAND_FORCE];
            end
            if (hit_famp)
                forced_amp_reg <= wd[synth_cfg_pkg::POS_FORCED_AMP +: 9];
            if (hit_start)
                amp_start_reg <= wd[synth_cfg_pkg::POS_AMP_START +: 9];
            if (hit_band)
                forced_band_reg <= wd[synth_cfg_pkg::POS_FORCED_BAND +: 8];
            if (hit_core)
            begin
                core_sel_reg <= wd[synth_cfg_pkg::POS_CORE_SEL +: 3];
                core_force_reg <= wd[synth_cfg_pkg::POS_CORE_FORCE];
            end
            if (hit_clk_div)
                cal_div_reg <= wd[synth_cfg_pkg::POS_CAL_CLK_DIV +: 3];
            if (hit_launch)
                launch_bit_reg <= wd[synth_cfg_pkg::POS_LAUNCH];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Launch pulse and launch counter. The act of writing a one launches,
    // even when the bit already reads one.

    wire logic launch_next = wr_ok && hit_launch && wd[synth_cfg_pkg::POS_LAUNCH];
    wire logic count_clear = wr_ok && hit_count;
    wire logic [7:0] count_next = count_clear ? 8'h00 : launch_count_reg + 8'h01;

    // Forced amplitude replaces the search start as the seed handed on.
    wire logic [8:0] amp_seed_next = amp_force_reg ? forced_amp_reg : amp_start_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            launch_reg <= 1'b0;
            launch_count_reg <= 8'h00;
            amp_seed_reg <= synth_cfg_pkg::RST_AMP_START;
        end
        else
        begin
            launch_reg <= launch_next;
            amp_seed_reg <= amp_seed_next;
            if (count_clear || launch_next)
                launch_count_reg <= count_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration clock tick: one pclk pulse every 2^code cycles. Codes
    // above 3 are undefined for software, so they fall back to divide by 8.

    wire logic [2:0] div_mask = (cal_div_reg == 3'h0) ? 3'h0 :
                                (cal_div_reg == 3'h1) ? 3'h1 :
                                (cal_div_reg == 3'h2) ? 3'h3 : 3'h7;
    wire logic tick_next = ((tick_cnt_reg & div_mask) == div_mask);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_reg <= 3'h0;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + 3'h1;
            tick_reg <= tick_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;
    assign ref_doubler_en = doubler_reg;
    assign ref_scale_factor = scale_reg;
    assign ref_post_div = post_div_reg;
    assign ref_pre_div = pre_div_reg;
    assign pump_gain = pump_gain_reg;
    assign amplitude_cal_delay = amp_delay_reg;
    assign amplitude_force = amp_force_reg;
    assign band_force = band_force_reg;
    assign forced_amplitude = forced_amp_reg;
    assign amplitude_start = amp_start_reg;
    assign amplitude_seed = amp_seed_reg;
    assign forced_band = forced_band_reg;
    assign core_select = core_sel_reg;
    assign core_force = core_force_reg;
    assign cal_clk_div = cal_div_reg;
    assign cal_clk_tick = tick_reg;
    assign freq_calib_launch = launch_reg;

    ////////////////////////////////////////////////////////////////////////////

    doubler_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && hit_doubler) |=> (ref_doubler_en == $past(pwdata[12])))
        else $error("doubler enable did not follow the write");

    scale_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && hit_scaler) |=> (ref_scale_factor == $past(pwdata[11:7])))
        else $error("multiplier factor did not follow the write");

    post_div_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && hit_post) |=> (ref_post_div == $past(pwdata[11:4])))
        else $error("post-divider did not follow the write");

    pre_div_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && hit_pre) |=> (ref_pre_div == $past(pwdata[11:0])))
        else $error("pre-divider did not follow the write");

    pump_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && hit_pump && aligned) |=> (prdata[6:4] == pump_gain && prdata[15:7] == 9'h03C))
        else $error("charge-pump readback wrong");

    amp_seed_a: assert property (@(posedge pclk) disable iff (!presetn)
        amplitude_force ##1 (amplitude_force && $stable(forced_amplitude)) |-> (amplitude_seed == forced_amplitude))
        else $error("forced amplitude not used as seed");

    start_seed_a: assert property (@(posedge pclk) disable iff (!presetn)
        !amplitude_force ##1 (!amplitude_force && $stable(amplitude_start)) |-> (amplitude_seed == amplitude_start))
        else $error("search start not used as seed");

    band_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && hit_band) |=> (forced_band == $past(pwdata[7:0])))
        else $error("forced band did not follow the write");

    core_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && hit_core) |=> (core_select == $past(pwdata[13:11]) && core_force == $past(pwdata[10])))
        else $error("core select or force did not follow the write");

    tick_div8_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cal_clk_tick && cal_clk_div == 3'h3 && $stable(cal_clk_div)) |=> (!cal_clk_tick || cal_clk_div != 3'h3) [*7]
        ##1 (cal_clk_tick || cal_clk_div != 3'h3))
        else $error("calibration tick spacing wrong for divide by 8");

    launch_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && hit_launch && pwdata[3]) |=> freq_calib_launch ##1 !freq_calib_launch)
        else $error("launch write did not give a one-cycle pulse");

    no_stray_launch_a: assert property (@(posedge pclk) disable iff (!presetn)
        freq_calib_launch |-> $past(wr_ok && hit_launch && pwdata[3]))
        else $error("launch pulse without a launch write");

endmodule

//--- test/test_synth_cfg_regs.sv
// Self-checking bench for the synthesizer configuration register bank.
// Assumes the bank answers APB with no wait states and resets asynchronously.
`timescale 1ns/100ps
module test_synth_cfg_regs;
////////////////////////////////////////////////////////////////////////////////
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic [3:0] pstrb;
logic ref_doubler_en, amplitude_force, band_force, core_force, cal_clk_tick, freq_calib_launch;
logic [4:0] ref_scale_factor;
logic [7:0] ref_post_div, amplitude_cal_delay, forced_band;
logic [11:0] ref_pre_div;
logic [2:0] pump_gain, core_select, cal_clk_div;
logic [8:0] forced_amplitude, amplitude_start, amplitude_seed;
int n_fail, cmp_count;
// Register indices, reset readback and new readback; new values keep the fixed bits as shown.
logic [7:0] idx_t [11] = '{8'h04, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h10, 8'h11, 8'h13, 8'h14};
logic [15:0] rst_t [11] = '{16'h0A43, 16'h2000, 16'h0604, 16'h10D8, 16'h0018, 16'h5001, 16'h1E70, 16'h0080,
    16'h00FA, 16'h27B7, 16'hF848};
logic [15:0] new_t [11] = '{16'h1943, 16'h6800, 16'h1604, 16'h13D8, 16'h0FF8, 16'h5FFF, 16'h1E50, 16'h01FF,
    16'h0100, 16'h275A, 16'hCC48};
////////////////////////////////////////////////////////////////////////////////
synth_cfg_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ref_doubler_en(ref_doubler_en), .ref_scale_factor(ref_scale_factor), .ref_post_div(ref_post_div),
    .ref_pre_div(ref_pre_div), .pump_gain(pump_gain), .amplitude_cal_delay(amplitude_cal_delay),
    .amplitude_force(amplitude_force), .band_force(band_force), .forced_amplitude(forced_amplitude),
    .amplitude_start(amplitude_start), .amplitude_seed(amplitude_seed), .forced_band(forced_band),
    .core_select(core_select), .core_force(core_force), .cal_clk_div(cal_clk_div),
    .cal_clk_tick(cal_clk_tick), .freq_calib_launch(freq_calib_launch));
////////////////////////////////////////////////////////////////////////////////
task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask
task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
        n_fail++;
        $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
endtask
// Pready is sampled at the rising edge; the task returns half a cycle later so outputs have settled.
task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] st,
    input logic [1:0] lo);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, lo};
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
        @(posedge pclk);
        i++;
    end
    while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1)
    begin
        n_fail++;
        $display("CHECK FAILED at %0t: no ready answer", $time);
        print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
endtask
task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    apb(1'b1, idx, {16'h0000, d}, 4'hF, 2'b00);
endtask
task automatic rdr(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0, 4'hF, 2'b00);
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_reset_values;
    check({ref_doubler_en, ref_scale_factor, ref_post_div, ref_pre_div}, {1'b0, 5'h01, 8'h01, 12'h001}, "path");
    check({pump_gain, amplitude_cal_delay, amplitude_force, band_force}, {3'h7, 8'h0A, 2'b00}, "cal");
    check({forced_amplitude, amplitude_start, forced_band}, {9'h080, 9'h0FA, 8'hB7}, "values");
    check({core_select, core_force, cal_clk_div, amplitude_seed}, {3'h7, 1'b0, 3'h3, 9'h0FA}, "core");
    for (int i = 0; i < 11; i++)
    begin
        rdr(idx_t[i]);
        check({err, rd}, {1'b0, 16'h0000, rst_t[i]}, "reset readback");
    end
endtask
task automatic t_write_fields;
    for (int i = 0; i < 11; i++)
        wr(idx_t[i], new_t[i]);
    for (int i = 0; i < 11; i++)
    begin
        rdr(idx_t[i]);
        check(rd, {16'h0000, new_t[i]}, "readback");
    end
    check({ref_doubler_en, ref_scale_factor, ref_post_div, ref_pre_div}, {1'b1, 5'h07, 8'hFF, 12'hFFF}, "path");
    check({pump_gain, amplitude_cal_delay, amplitude_force, band_force}, {3'h5, 8'h19, 2'b11}, "cal");
    check({forced_amplitude, amplitude_start, forced_band, amplitude_seed}, {9'h1FF, 9'h100, 8'h5A, 9'h1FF}, "vals");
    check({core_select, core_force}, {3'h1, 1'b1}, "core");
endtask
task automatic t_codes;
    logic [4:0] sc [3] = '{5'd1, 5'd3, 5'd7};
    logic [2:0] pg [6] = '{3'd0, 3'd1, 3'd3, 3'd4, 3'd5, 3'd7};
    for (int i = 0; i < 3; i++)
    begin
        wr(8'h0A, 16'h1058 | ({11'h000, sc[i]} << 7));
        check(ref_scale_factor, sc[i], "scale code");
    end
    for (int i = 0; i < 6; i++)
    begin
        wr(8'h0E, 16'h1E00 | ({13'h0000, pg[i]} << 4));
        check(pump_gain, pg[i], "pump code");
    end
endtask
task automatic t_seed_launch;
    wr(8'h08, 16'h2000);
    repeat (2) @(negedge pclk);
    check({amplitude_force, amplitude_seed}, {1'b0, 9'h100}, "seed from start");
    wr(8'h00, 16'h2418);
    check(freq_calib_launch, 1'b1, "launch pulse");
    @(negedge pclk);
    check(freq_calib_launch, 1'b0, "launch ends");
    wr(8'h00, 16'h2410);
    check(freq_calib_launch, 1'b0, "no launch on zero");
    @(negedge pclk);
    check(freq_calib_launch, 1'b0, "no late launch");
    rdr(8'h00);
    check(rd, 32'h2410, "launch bit readback");
    rdr(8'h02);
    check(rd, 32'h1, "launch count");
    wr(8'h02, 16'h0000);
    rdr(8'h02);
    check(rd, 32'h0, "launch count cleared");
endtask
task automatic t_tick;
    int n;
    for (int d = 0; d < 4; d++)
    begin
        wr(8'h01, 16'h0808 | 16'(d));
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (cal_clk_tick !== 1'b1 && n < 20);
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (cal_clk_tick !== 1'b1 && n < 20);
        check(n, 1 << d, "tick period");
    end
    rdr(8'h01);
    check(rd, 32'h080B, "divider readback");
endtask
task automatic t_errors;
    rdr(8'h03);
    check({err, rd}, {1'b1, 32'h0}, "unmapped read");
    apb(1'b1, 8'h09, 32'h0604, 4'h0, 2'b00);
    check({err, ref_doubler_en}, 2'b11, "bad strobe write");
    apb(1'b0, 8'h09, 32'h0, 4'hF, 2'b01);
    check(err, 1'b1, "misaligned read");
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
end
initial
begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (3) @(posedge pclk);
    check(freq_calib_launch, 1'b0, "launch held in reset");
    presetn <= 1'b1;
    t_reset_values();
    t_write_fields();
    t_codes();
    t_seed_launch();
    t_tick();
    t_errors();
    print_verdict();
end
endmodule
